/* File: rtl/btm_pkg.sv */
// Contract
// - Up to three independent limit channels compared.
// - Crossing sends switch, brightness or scene.
// - Own output per channel; count enables.
// - Switching format sends 1-bit on/off.
// - Brightness format sends byte 0..100.
// - Scene format sends byte 0..64.
// - Upper type: lower equals limit minus hysteresis.
// - Lower type: upper equals limit plus hysteresis.
// - Emit on rise, fall, or both.
// - Fixed hysteresis; thresholds recomputed on load.
// - External 2-byte preset becomes the limit.
// - Preset stays until next preset, teach or overwriting reprogram.
// - Teach-active captures current brightness as limit.
// - Opposite teach polarity restores configured limit.
// - Both-polarity teach never restores configured limit.
// - Teach capture discards previous preset.
// - Every teach-active telegram captures afresh.
// - Feedback sends limit on change, reprogram, return.
// - Reprogram option: overwrite or keep active limit.
// - Configured limit used until first override.
// - Overrides survive bus-voltage failure.
// - Disable never blocks preset or teach.
// - Disabled channel neither compares nor sends crossing telegrams; feedback is still sent unless the channel lies beyond the count.
package btm_pkg;
   localparam int BTM_NCH = 3;
   // APB register byte offsets.
   localparam logic [7:0] BTM_CTRL_OFS   = 8'h00;
   localparam logic [7:0] BTM_BRIGHT_OFS = 8'h04;
   localparam logic [7:0] BTM_EVENT_OFS  = 8'h08;
   localparam logic [7:0] BTM_STAT_OFS   = 8'h0c;
   localparam logic [7:0] BTM_CH_BASE    = 8'h10;
   localparam logic [7:0] BTM_CH_STRIDE  = 8'h10;
   localparam logic [7:0] BTM_CH_CFG     = 8'h00;
   localparam logic [7:0] BTM_CH_LIM     = 8'h04;
   localparam logic [7:0] BTM_CH_HYS     = 8'h08;
   localparam logic [7:0] BTM_CH_VAL     = 8'h0c;
   // CTRL fields.
   localparam int BTM_CTRL_CNT_LSB = 0;
   localparam int BTM_CTRL_OVW_BIT = 2;
   localparam int BTM_CTRL_FBD_BIT = 3;
   localparam int BTM_CTRL_DIS_LSB = 4;
   // EVENT write bits (pulses).
   localparam int BTM_EV_PROG_BIT = 0;
   localparam int BTM_EV_RET_BIT  = 1;
   // Channel CFG fields.
   localparam int BTM_CFG_FMT_LSB  = 0;
   localparam int BTM_CFG_TYPE_BIT = 2;
   localparam int BTM_CFG_RISE_BIT = 3;
   localparam int BTM_CFG_FALL_BIT = 4;
   localparam int BTM_CFG_TCH_LSB  = 5;
   localparam int BTM_CFG_FBA_BIT  = 7;
   localparam int BTM_CFG_DIS_BIT  = 8;
   // Channel VAL fields: value on rise in [7:0], on fall in [15:8].
   localparam logic [7:0] BTM_PCT_MAX   = 8'h64;
   localparam logic [7:0] BTM_SCENE_MAX = 8'h40;
   localparam logic [1:0] BTM_CNT_RST   = 2'h3;
   localparam logic [15:0] BTM_LIM_RST  = 16'h0000;
   // Delay of feedback after bus return.
   localparam int BTM_FB_DELAY_US = 100;
   localparam int BTM_CLK_MHZ     = 100;
   localparam int BTM_FB_DELAY_CYC = BTM_FB_DELAY_US * BTM_CLK_MHZ;
   typedef enum logic [1:0] {
      BTM_FMT_SWITCH,
      BTM_FMT_BRIGHT,
      BTM_FMT_SCENE
   } btm_fmt_e;
   typedef enum logic [1:0] {
      BTM_TCH_ONE,
      BTM_TCH_ZERO,
      BTM_TCH_BOTH
   } btm_tch_e;
   typedef enum logic [1:0] {
      BTM_SRC_CFG,
      BTM_SRC_PRESET,
      BTM_SRC_TEACH
   } btm_src_e;
endpackage : btm_pkg

/* File: rtl/btm_monitor.sv */
`timescale 1ns/1ns
// Brightness threshold monitor: three limit channels behind an APB slave.
module btm_monitor
   import btm_pkg::*;
#(
   parameter int FB_DELAY_CYC = btm_pkg::BTM_FB_DELAY_CYC
) (
   input  wire logic                      pclk,        // Bus clock.
   input  wire logic                      presetn,     // Async reset, low.
   input  wire logic                      psel,        // APB select.
   input  wire logic                      penable,     // APB enable.
   input  wire logic                      pwrite,      // APB direction.
   input  wire logic [7:0]                paddr,       // APB byte address.
   input  wire logic [31:0]               pwdata,      // APB write data.
   output logic      [31:0]               prdata,      // APB read data.
   output logic                           pready,      // APB ready.
   output logic                           pslverr,     // APB error.
   input  wire logic [btm_pkg::BTM_NCH-1:0] preset_stb, // Preset pulse.
   input  wire logic [15:0]               preset_val,  // Preset, 9.004.
   input  wire logic [btm_pkg::BTM_NCH-1:0] teach_stb,  // Teach pulse.
   input  wire logic [btm_pkg::BTM_NCH-1:0] teach_val,  // Teach bit.
   output logic [btm_pkg::BTM_NCH-1:0]    out_stb,     // Telegram pulse.
   output logic [btm_pkg::BTM_NCH-1:0]    out_bit,     // Switching value.
   output logic [23:0]                    out_byte,    // Byte per channel.
   output logic [btm_pkg::BTM_NCH-1:0]    fb_stb,      // Feedback pulse.
   output logic [47:0]                    fb_val       // Limit per channel.
);
   import btm_pkg::*;

   // Bus decode.
   wire        acc    = psel && penable;
   wire        wr     = acc && pwrite;
   wire [3:0]  ridx   = paddr[7:4];
   wire [3:0]  roff   = paddr[3:0];
   wire        glob   = (ridx == 4'h0);
   wire        ch_hit = (ridx >= 4'h1) && (ridx <= 4'(BTM_NCH));
   wire [1:0]  chsel  = 2'(ridx - 4'h1);
   wire        wr_ctl = wr && (paddr == BTM_CTRL_OFS);
   wire        wr_br  = wr && (paddr == BTM_BRIGHT_OFS);
   wire        wr_ev  = wr && (paddr == BTM_EVENT_OFS);
   wire        prog   = wr_ev && pwdata[BTM_EV_PROG_BIT];
   wire        bret   = wr_ev && pwdata[BTM_EV_RET_BIT];
   wire        mapped = (glob && paddr[1:0] == 2'h0) ||
                        (ch_hit && paddr[1:0] == 2'h0);

   logic [1:0]  cnt_r;
   logic        ovw_r, fbd_r;
   logic [2:0]  dis_prog_r;
   logic [15:0] bright_r;
   logic [(FB_DELAY_CYC > 1 ? $clog2(FB_DELAY_CYC+1) : 1):0] dly_r;
   logic        dly_pend_r;

   // Global control, brightness and the delayed return-feedback timer.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r      <= BTM_CNT_RST;
         ovw_r      <= 1'b0;
         fbd_r      <= 1'b0;
         dis_prog_r <= 3'h0;
         bright_r   <= 16'h0000;
         dly_r      <= '0;
         dly_pend_r <= 1'b0;
      end else begin
         if (wr_ctl) begin
            cnt_r      <= pwdata[BTM_CTRL_CNT_LSB +: 2];
            ovw_r      <= pwdata[BTM_CTRL_OVW_BIT];
            fbd_r      <= pwdata[BTM_CTRL_FBD_BIT];
            dis_prog_r <= pwdata[BTM_CTRL_DIS_LSB +: 3];
         end
         if (wr_br)
            bright_r <= pwdata[15:0];
         if (bret && fbd_r) begin
            dly_pend_r <= 1'b1;
            dly_r      <= '0;
         end else if (dly_pend_r) begin
            dly_r <= dly_r + 1'b1;
            if (dly_r == ($bits(dly_r))'(FB_DELAY_CYC - 1))
               dly_pend_r <= 1'b0;
         end
      end
   end

   // Feedback trigger after bus return, immediate or delayed.
   wire ret_fire = (bret && !fbd_r) ||
                   (dly_pend_r &&
                    dly_r == ($bits(dly_r))'(FB_DELAY_CYC - 1));

   logic [8:0]  cfg_r  [BTM_NCH];
   logic [15:0] lcfg_r [BTM_NCH];
   logic [15:0] hys_r  [BTM_NCH];
   logic [15:0] val_r  [BTM_NCH];
   logic [15:0] lim_r  [BTM_NCH];
   btm_src_e    src_r  [BTM_NCH];
   logic [1:0]  zone_r [BTM_NCH];
   logic [15:0] rd_ch;

   genvar g;
   generate
      for (g = 0; g < BTM_NCH; g++) begin : gch
         localparam logic [1:0] CH = 2'(g);
         wire en      = (CH < cnt_r);
         wire wsel    = wr && ch_hit && chsel == CH;
         wire w_cfg   = wsel && roff == BTM_CH_CFG[3:0];
         wire w_lim   = wsel && roff == BTM_CH_LIM[3:0];
         wire w_hys   = wsel && roff == BTM_CH_HYS[3:0];
         wire w_val   = wsel && roff == BTM_CH_VAL[3:0];
         btm_fmt_e fmt;
         btm_tch_e tmode;
         assign fmt   = btm_fmt_e'(cfg_r[g][BTM_CFG_FMT_LSB +: 2]);
         assign tmode = btm_tch_e'(cfg_r[g][BTM_CFG_TCH_LSB +: 2]);
         wire is_up   = cfg_r[g][BTM_CFG_TYPE_BIT];
         wire dis     = cfg_r[g][BTM_CFG_DIS_BIT] || !en;
         // Teach decode; either polarity in both mode is a capture.
         wire t_act   = teach_stb[g] && (tmode == BTM_TCH_BOTH ||
                        teach_val[g] == (tmode == BTM_TCH_ONE));
         wire t_rst   = teach_stb[g] && !t_act &&
                        tmode != BTM_TCH_BOTH;
         wire p_ld    = preset_stb[g];
         wire prg_rst = prog && (ovw_r || src_r[g] == BTM_SRC_CFG);
         // Thresholds, saturating so a wrap never fakes a crossing.
         wire [16:0] sum = {1'b0, lim_r[g]} + {1'b0, hys_r[g]};
         wire [15:0] hi  = is_up ? lim_r[g] :
                           (sum[16] ? 16'hffff : sum[15:0]);
         wire [15:0] lo  = !is_up ? lim_r[g] :
                           (lim_r[g] > hys_r[g] ?
                            16'(lim_r[g] - hys_r[g]) : 16'h0000);
         wire above   = bright_r > hi;
         wire below   = bright_r < lo;
         wire rise    = above && zone_r[g] != 2'h1;
         wire fall    = below && zone_r[g] != 2'h2;
         wire fire    = !dis && ((rise && cfg_r[g][BTM_CFG_RISE_BIT]) ||
                                 (fall && cfg_r[g][BTM_CFG_FALL_BIT]));
         wire [7:0] v_r = val_r[g][7:0];
         wire [7:0] v_f = val_r[g][15:8];
         wire [7:0] vb  = rise ? v_r : v_f;
         wire [7:0] cap = (fmt == BTM_FMT_SCENE) ? BTM_SCENE_MAX :
                          BTM_PCT_MAX;
         wire [7:0] ob  = vb > cap ? cap : vb;
         wire [15:0] lim_nxt = t_act ? bright_r :
                               p_ld  ? preset_val :
                               (t_rst || prg_rst) ? lcfg_r[g] : lim_r[g];
         wire lim_chg = t_act || p_ld || t_rst || prg_rst;
         wire fb_go   = cfg_r[g][BTM_CFG_FBA_BIT] && en &&
                        (lim_chg || prog || ret_fire);

         // Limit source; the bus return pulse leaves it alone.
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               src_r[g] <= BTM_SRC_CFG;
               lim_r[g] <= BTM_LIM_RST;
            end else begin
               lim_r[g] <= w_lim && src_r[g] == BTM_SRC_CFG &&
                           !lim_chg ? pwdata[15:0] : lim_nxt;
               if (t_act)
                  src_r[g] <= BTM_SRC_TEACH;
               else if (p_ld)
                  src_r[g] <= BTM_SRC_PRESET;
               else if (t_rst || prg_rst)
                  src_r[g] <= BTM_SRC_CFG;
            end
         end

         // Configuration and zone tracking for one-shot crossings.
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cfg_r[g]  <= 9'h018;
               lcfg_r[g] <= BTM_LIM_RST;
               hys_r[g]  <= 16'h0000;
               val_r[g]  <= 16'h0064;
               zone_r[g] <= 2'h0;
            end else begin
               if (w_cfg)
                  cfg_r[g] <= pwdata[8:0];
               else if (prog)
                  cfg_r[g][BTM_CFG_DIS_BIT] <= dis_prog_r[g];
               if (w_lim)
                  lcfg_r[g] <= pwdata[15:0];
               if (w_hys)
                  hys_r[g] <= pwdata[15:0];
               if (w_val)
                  val_r[g] <= pwdata[15:0];
               if (dis)
                  zone_r[g] <= 2'h0;
               else if (above)
                  zone_r[g] <= 2'h1;
               else if (below)
                  zone_r[g] <= 2'h2;
            end
         end

         // Registered channel outputs.
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               out_stb[g]          <= 1'b0;
               out_bit[g]          <= 1'b0;
               out_byte[8*g +: 8]  <= 8'h00;
               fb_stb[g]           <= 1'b0;
               fb_val[16*g +: 16]  <= 16'h0000;
            end else begin
               out_stb[g] <= fire;
               if (fire) begin
                  out_bit[g]         <= rise;
                  out_byte[8*g +: 8] <= (fmt == BTM_FMT_SWITCH) ?
                                        8'h00 : ob;
               end
               fb_stb[g]          <= fb_go;
               fb_val[16*g +: 16] <= lim_nxt;
            end
         end
      end
   endgenerate

   // Read mux.
   always_comb begin
      rd_ch = 16'h0000;
      for (int i = 0; i < BTM_NCH; i++) begin
         if (chsel == 2'(i)) begin
            case (roff)
               BTM_CH_CFG[3:0]: rd_ch = {7'h00, cfg_r[i]};
               BTM_CH_LIM[3:0]: rd_ch = lcfg_r[i];
               BTM_CH_HYS[3:0]: rd_ch = hys_r[i];
               BTM_CH_VAL[3:0]: rd_ch = val_r[i];
               default:         rd_ch = 16'h0000;
            endcase
         end
      end
   end

   wire [31:0] stat = {10'h000, 2'(src_r[2]), 2'(src_r[1]),
                       2'(src_r[0]), lim_r[0]};
   wire [31:0] rd_g = (roff == BTM_CTRL_OFS[3:0]) ?
                         {25'h0, dis_prog_r, fbd_r, ovw_r, cnt_r} :
                      (roff == BTM_BRIGHT_OFS[3:0]) ? {16'h0, bright_r} :
                      (roff == BTM_STAT_OFS[3:0]) ? stat : 32'h0;

   // Zero-wait APB answer: pready rises in the first access cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         // A refused read returns zero rather than an aliased channel word.
         prdata  <= !mapped ? 32'h0 : glob ? rd_g : {16'h0, rd_ch};
      end
   end
endmodule : btm_monitor

/* File: verif/btm_monitor_assertions.sv */
`timescale 1ns/1ns
// Watches the bus handshake and the telegram outputs of the monitor.
module btm_monitor_assertions (
   input wire logic                        pclk,       // Clock.
   input wire logic                        presetn,    // Reset, low.
   input wire logic                        psel,       // Select.
   input wire logic                        penable,    // Enable.
   input wire logic                        pwrite,     // Direction.
   input wire logic [31:0]                 prdata,     // Read data.
   input wire logic                        pready,     // Ready.
   input wire logic                        pslverr,    // Error.
   input wire logic [btm_pkg::BTM_NCH-1:0] preset_stb, // Preset pulse.
   input wire logic [15:0]                 preset_val, // Preset value.
   input wire logic [btm_pkg::BTM_NCH-1:0] teach_stb,  // Teach pulse.
   input wire logic [btm_pkg::BTM_NCH-1:0] out_stb,    // Telegram pulse.
   input wire logic [btm_pkg::BTM_NCH-1:0] out_bit,    // Switch value.
   input wire logic [23:0]                 out_byte,   // Byte values.
   input wire logic [47:0]                 fb_val      // Active limits.
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // The slave answers each setup within two edges, one cycle wide.
   a_ready_once: assert property (pready |=> !pready)
      else $error("pready stood longer than one cycle.");
   a_setup_answer: assert property (psel && !penable |-> ##[1:2] pready)
      else $error("No answer to a bus request in time.");
   a_err_ready: assert property (pslverr |-> pready && psel && penable)
      else $error("Error flagged outside an access.");
   a_err_read0: assert property (pslverr && !pwrite |-> prdata == 32'h0)
      else $error("Refused read returned data.");
   // A crossing yields one pulse, never a run of them.
   a_tg_single: assert property (!(|(out_stb & $past(out_stb))))
      else $error("Telegram pulse on two cycles running.");
   // A capturing teach outranks preset, so only a lone preset is judged here.
   a_preset_load: assert property (preset_stb[0] && !teach_stb[0] |=>
      fb_val[15:0] == $past(preset_val))
      else $error("Preset not adopted as the limit.");
   a_byte_range: assert property (out_stb[2] |-> out_byte[23:16] <= 8'h64)
      else $error("Byte telegram out of range.");
   a_bit_with_tg: assert property ($changed(out_bit[0]) |-> out_stb[0])
      else $error("Switch value moved without a telegram.");
   c_rise: cover property (out_stb[0] && out_bit[0]);
   c_refused: cover property (pslverr);
   c_teach: cover property (teach_stb[0]);
endmodule // btm_monitor_assertions

bind btm_monitor btm_monitor_assertions u_chk (.pclk, .presetn, .psel,
   .penable, .pwrite, .prdata, .pready, .pslverr, .preset_stb,
   .preset_val, .teach_stb, .out_stb, .out_bit, .out_byte, .fb_val);

/* File: verif/btm_peer.sv */
`timescale 1ns/1ns
// Other bus subscribers: send presets and teach telegrams, count output.
module btm_peer (
   input  wire logic                   pclk,       // Clock.
   input  wire logic [btm_pkg::BTM_NCH-1:0] out_stb, // Telegrams.
   output logic [btm_pkg::BTM_NCH-1:0] preset_stb, // Preset pulse.
   output logic [15:0]                 preset_val, // Preset value.
   output logic [btm_pkg::BTM_NCH-1:0] teach_stb,  // Teach pulse.
   output logic [btm_pkg::BTM_NCH-1:0] teach_val   // Teach value.
);
   import btm_pkg::*;
   int tg_cnt;
   // Quiet line at start; the preset value line carries a filler pattern.
   initial begin
      preset_stb = '0;
      teach_stb = '0;
      preset_val = 16'h5a5a;
      teach_val = '0;
      tg_cnt = 0;
   end
   // Each pulse is one telegram on the line, whatever channel sent it.
   always @(posedge pclk) tg_cnt <= tg_cnt + $countones(out_stb);
   // A stale value is scrambled so nothing can lean on it.
   task automatic preset(input int c, input logic [15:0] v);
      @(posedge pclk);
      preset_stb[c] <= 1'b1;
      preset_val <= v;
      @(posedge pclk);
      preset_stb <= '0;
      preset_val <= ~v;
   endtask
   // Repeats of the same value are sent as separate telegrams.
   task automatic teach(input int c, input logic b);
      @(posedge pclk);
      teach_stb[c] <= 1'b1;
      teach_val[c] <= b;
      @(posedge pclk);
      teach_stb <= '0;
      teach_val[c] <= ~b;
   endtask
endmodule // btm_peer

/* File: verif/testbench.sv */
`timescale 1ns/1ns
// Self-checking bench for the brightness threshold monitor.
module testbench;
   import btm_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, upt;
   logic [7:0] paddr, vr, vf;
   logic [31:0] pwdata, prdata, rd;
   logic [BTM_NCH-1:0] preset_stb, teach_stb, teach_val, out_stb;
   logic [BTM_NCH-1:0] out_bit, fb_stb;
   logic [15:0] preset_val, lim, hy, hi, lo, b1, b2, v[5];
   logic [23:0] out_byte;
   logic [47:0] fb_val;
   logic [7:0] y[5];
   logic w[5], rise, fall;
   int n_fail, cmp_count, base, n_wait;
   // Short return delay so the delayed feedback path is reached quickly.
   localparam int FB_DLY = 10;
   btm_monitor #(.FB_DELAY_CYC(FB_DLY)) DUT (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .preset_stb,
      .preset_val, .teach_stb, .teach_val, .out_stb, .out_bit, .out_byte,
      .fb_stb, .fb_val);
   btm_peer P (.pclk, .out_stb, .preset_stb, .preset_val, .teach_stb,
      .teach_val);
   // Free-running 100 MHz clock.
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   // One transfer; the request is held until pready is seen high.
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
      if (n >= 20) chk(32'h0, 32'h1);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd & m, e);
   endtask
   function automatic logic [7:0] ca(input int c, input logic [7:0] o);
      return 8'(BTM_CH_BASE + BTM_CH_STRIDE * c + o);
   endfunction
   function automatic logic [7:0] clampv(input int c, input logic [7:0] x);
      logic [7:0] m;
      m = (c == 1) ? BTM_PCT_MAX : BTM_SCENE_MAX;
      return (x > m) ? m : x;
   endfunction
   // Waits a bounded time for a telegram, or for its absence.
   task automatic tg(input int c, input logic b, input logic [7:0] yy,
                     input logic ww);
      int n;
      n = 0;
      while (out_stb[c] !== 1'b1 && n < 10) begin
         @(negedge pclk);
         n++;
      end
      chk(32'(out_stb[c]), 32'(ww));
      if (ww && c == 0) chk(32'(out_bit[0]), 32'(b));
      if (ww && c != 0) chk(32'(out_byte[8*c+:8]), 32'(yy));
      @(negedge pclk);
   endtask
   // Feedback pulse stands one cycle, then the new limit must be shown.
   task automatic fbc(input logic [15:0] e);
      @(negedge pclk);
      chk(32'(fb_stb[0]), 32'h1);
      @(negedge pclk);
      chk(32'(fb_stb[0]), 32'h0);
      chk(32'(fb_val[15:0]), 32'(e));
   endtask
   task automatic end_sim;
      $display("TB: %0d compares, %0d errors", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Cuts a hang short well beyond the expected run time.
   initial begin
      repeat (60000) @(posedge pclk);
      n_fail++;
      end_sim();
   end
   // Main sequence: reset values, per-channel crossings, limit sources.
   initial begin
      {psel, penable, pwrite, presetn} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      n_fail = 0;
      cmp_count = 0;
      void'($urandom(32'h5fed6728));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rdc(BTM_CTRL_OFS, 32'h3, 32'h3);
      rdc(ca(0, BTM_CH_CFG), 32'h7f, 32'h18);
      rdc(ca(0, BTM_CH_VAL), 32'hffff, 32'h64);
      rdc(ca(0, BTM_CH_LIM), 32'hffff, 32'h0);
      rdc(8'hf0, 32'hffffffff, 32'h0);
      chk(32'(er), 32'h1);
      // Other channels are disabled, so any stray telegram shows up.
      for (int c = 0; c < 3; c++) begin
         lim = 16'($urandom_range(16'h7000, 16'h0100));
         hy = 16'($urandom_range(255, 4));
         vr = 8'($urandom_range(255, 0));
         vf = 8'($urandom_range(255, 0));
         upt = (c == 1);
         rise = (c != 2);
         fall = (c != 1);
         hi = upt ? lim : lim + hy;
         lo = upt ? lim - hy : lim;
         for (int k = 0; k < 3; k++)
            apb(1'b1, ca(k, BTM_CH_CFG), (k == c) ?
               {23'h0, 4'h0, fall, rise, upt, 2'(c)} : 32'h100);
         apb(1'b1, ca(c, BTM_CH_VAL), {16'h0, vf, vr});
         apb(1'b1, ca(c, BTM_CH_LIM), 32'(lim));
         apb(1'b1, ca(c, BTM_CH_HYS), 32'(hy));
         apb(1'b1, BTM_BRIGHT_OFS, 32'(lo - 16'h1));
         repeat (10) @(posedge pclk);
         base = P.tg_cnt;
         v = '{lo + hy / 2, hi + 16'h1, hi + 16'h2, lo + hy / 2, lo - 16'h1};
         w = '{1'b0, rise, 1'b0, 1'b0, fall};
         y = '{8'h0, clampv(c, vr), 8'h0, 8'h0, clampv(c, vf)};
         for (int s = 0; s < 5; s++) begin
            apb(1'b1, BTM_BRIGHT_OFS, 32'(v[s]));
            tg(c, s == 1, y[s], w[s]);
         end
         chk(32'(P.tg_cnt), 32'(base + rise + fall));
      end
      b1 = 16'($urandom_range(16'hfff0, 16'h0010));
      b2 = b1 ^ 16'h0808;
      apb(1'b1, ca(0, BTM_CH_CFG), 32'h80);
      apb(1'b1, ca(0, BTM_CH_LIM), 32'h1234);
      rdc(BTM_STAT_OFS, 32'h3ffff, 32'h01234);
      P.preset(0, b1 ^ 16'h3c3c);
      fbc(b1 ^ 16'h3c3c);
      apb(1'b1, BTM_BRIGHT_OFS, 32'(b1));
      P.teach(0, 1'b1);
      fbc(b1);
      rdc(BTM_STAT_OFS, 32'h30000, 32'h20000);
      apb(1'b1, BTM_BRIGHT_OFS, 32'(b2));
      P.teach(0, 1'b1);
      fbc(b2);
      apb(1'b1, BTM_EVENT_OFS, 32'h2);
      fbc(b2);
      apb(1'b1, BTM_CTRL_OFS, 32'h3);
      apb(1'b1, BTM_EVENT_OFS, 32'h1);
      fbc(b2);
      apb(1'b1, BTM_CTRL_OFS, 32'h7);
      apb(1'b1, BTM_EVENT_OFS, 32'h1);
      fbc(16'h1234);
      P.teach(0, 1'b1);
      P.teach(0, 1'b0);
      fbc(16'h1234);
      apb(1'b1, ca(0, BTM_CH_CFG), 32'hc0);
      P.teach(0, 1'b0);
      fbc(b2);
      // Zero-active teach: a zero captures, a one restores the setting.
      apb(1'b1, ca(0, BTM_CH_CFG), 32'ha0);
      apb(1'b1, BTM_BRIGHT_OFS, 32'(b1));
      P.teach(0, 1'b0);
      fbc(b1);
      P.teach(0, 1'b1);
      fbc(16'h1234);
      apb(1'b1, ca(0, BTM_CH_CFG), 32'h1c0);
      P.preset(0, b1);
      fbc(b1);
      // Delayed feedback after bus return; the override must survive.
      apb(1'b1, BTM_CTRL_OFS, 32'hf);
      apb(1'b1, BTM_EVENT_OFS, 32'h2);
      n_wait = 0;
      @(negedge pclk);
      while (fb_stb[0] !== 1'b1 && n_wait < 40) begin
         n_wait++;
         @(negedge pclk);
      end
      chk(32'(n_wait), 32'(FB_DLY));
      chk(32'(fb_val[15:0]), 32'(b1));
      end_sim();
   end
endmodule // testbench
